// ### hw/asrp_port.sv
/*
 * serial result port of a converter whose result pins double as parallel
 * bits: result coding, internal-clock master frames with frame marker,
 * external-clock slave shifting with daisy chain, overrun detection, and
 * a small status/mask register port with one interrupt.
 * assumes conversion strobes and result come from logic on core_clk;
 * all pins and the external serial clock are asynchronous to core_clk.
 */
// Implementation choices: the address-and-strobe port and the address map.
`default_nettype none

// Operation
// - parallel mode drives shared pins as bits 5-11
// - frame marker polarity set by sync select
// - clock invert applies to both clock sources
// - source select picks chain input or read mode
// - chain level appears sixteen clocks after start
// - read mode picks during-conversion or after-conversion
// - result shifted out most significant bit first
// - coding select chooses serial word coding
// - low coding select inverts the top bit
// - internal clock: data stable across both edges
// - external clock: update edge, host samples opposite
// - source select makes clock pin output or input
// - low selects internal clock, high external clock
// - frame marker only meaningful with internal clock
// - frame marker active while serial data valid
// - unfinished external read overrun discards data, flags
// - external clock ignored while chip select high
module asrp_port
	import asrp_pkg::*;
#(
	parameter int WORD_W      = RESULT_W,
	parameter int QUARTER_CYC = SCLK_QUARTER_CYC
)(
	input  wire logic                 core_clk,
	input  wire logic                 arst_n,
	input  wire logic                 port_style_select,
	input  wire logic                 clock_source_select,
	input  wire logic                 output_coding_select,
	input  wire logic                 cs_n,
	input  wire logic                 conv_start,
	input  wire logic                 conv_done,
	input  wire logic [WORD_W-1:0]    conv_result,
	input  wire logic [SHARED_W-1:0]  pin_d_in,
	output logic      [SHARED_W-1:0]  pin_d_out,
	output logic      [SHARED_W-1:0]  pin_d_oe,
	input  wire logic [3:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	output logic                      irq
);

	localparam int CNT_W  = $clog2(WORD_W + 1);
	localparam int TICK_W = $clog2(QUARTER_CYC + 1);
	localparam logic [CNT_W-1:0]  WORD_LAST    = CNT_W'(WORD_W);
	localparam logic [TICK_W-1:0] QUARTER_LAST = TICK_W'(QUARTER_CYC - 1);
	if (WORD_W < SHARED_LSB + SHARED_W || QUARTER_CYC < 1)
	begin : g_bad_param
		$error("asrp_port: word narrower than shared pins or zero divider");
	end

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	wire  [SYNC_W-1:0] sync_raw = {cs_n, port_style_select, clock_source_select, output_coding_select, pin_d_in};
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1 <= SYNC_RESET;
			sync2 <= SYNC_RESET;
		end
		else
		begin
			sync1 <= sync_raw;
			sync2 <= sync1;
		end
	end

	wire serial_s  = sync2[SYNC_STYLE];
	wire ext_s     = sync2[SYNC_SOURCE];
	wire coding_s  = sync2[SYNC_CODING];
	wire cs_n_s    = sync2[SYNC_CS_N];
	wire sync_pol  = sync2[PIN_SYNC_POL];
	wire sclk_inv  = sync2[PIN_SCLK_INV];
	wire rdc_chain = sync2[PIN_CHAIN];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	asrp_state_type           state;
	asrp_state_type           next_state;
	logic [WORD_W-1:0]        result_q;
	logic [WORD_W-1:0]        shreg;
	logic [WORD_W-1:0]        next_shreg;
	logic                     serial_data_output;
	logic                     next_serial_data_output;
	logic [CNT_W-1:0]         bit_cnt;
	logic [CNT_W-1:0]         next_bit_cnt;
	logic [TICK_W-1:0]        tick_cnt;
	logic [1:0]               phase;
	logic                     sclk_raw;
	logic                     next_sclk_raw;
	logic                     loaded;
	logic                     next_loaded;
	logic                     ext_prev;
	logic [STAT_W-1:0]        status;
	logic [STAT_W-1:0]        mask;
	// low coding select flips top bit
	wire [WORD_W-1:0] coded_in = {conv_result[WORD_W-1] ^ ~coding_s, conv_result[WORD_W-2:0]};
	// source select decides role of the chain pin
	wire master      = serial_s && !ext_s;
	wire slave       = serial_s && ext_s;
	wire chain_bit   = slave ? rdc_chain : 1'b0;
	// read mode picks the start event
	wire start_evt   = master && state == ASRP_IDLE && (rdc_chain ? conv_start : conv_done);
	wire [WORD_W-1:0] load_word = (rdc_chain && !conv_done) ? result_q : coded_in;
	wire tick        = tick_cnt == QUARTER_LAST;
	wire run_tick    = state == ASRP_RUN && tick;
	wire bit_end     = run_tick && phase == 2'd3;
	wire master_done = bit_end && bit_cnt == WORD_LAST;
	// inversion applies to the sampled external clock too
	wire ext_eff     = sync2[PIN_SCLK] ^ sclk_inv;
	// effective rise updates, select gates it
	wire upd_edge    = slave && ext_eff && !ext_prev && !cs_n_s;
	wire slave_done  = upd_edge && loaded && bit_cnt == WORD_LAST - CNT_W'(1);
	// a new result before the read ends is an overrun
	wire ovr_evt     = slave && conv_done && loaded && bit_cnt != WORD_LAST;
	wire frame_evt   = master_done || slave_done;
	always_comb
	begin
		next_state    = state;
		next_shreg    = shreg;
		next_serial_data_output    = serial_data_output;
		next_bit_cnt  = bit_cnt;
		next_sclk_raw = sclk_raw;
		next_loaded   = loaded;
		// most significant bit leads the word
		if (start_evt)
		begin
			next_state    = ASRP_RUN;
			next_serial_data_output    = load_word[WORD_W-1];
			next_shreg    = {load_word[WORD_W-2:0], 1'b0};
			next_bit_cnt  = CNT_W'(1);
			next_sclk_raw = 1'b0;
		end
		else if (state == ASRP_RUN)
		begin
			// data moves a quarter bit away from either clock edge
			if (run_tick && phase == 2'd0)
				next_sclk_raw = 1'b1;
			if (run_tick && phase == 2'd2)
				next_sclk_raw = 1'b0;
			if (master_done || !master)
				next_state = ASRP_IDLE;
			else if (bit_end)
			begin
				next_serial_data_output   = shreg[WORD_W-1];
				next_shreg   = {shreg[WORD_W-2:0], 1'b0};
				next_bit_cnt = bit_cnt + CNT_W'(1);
			end
		end
		else if (slave)
		begin
			// current word dropped, new one takes its place
			if (conv_done)
			begin
				next_shreg   = coded_in;
				next_loaded  = 1'b1;
				next_bit_cnt = '0;
			end
			// chain bit enters the tail and exits sixteen edges later
			else if (upd_edge)
			begin
				next_serial_data_output = shreg[WORD_W-1];
				next_shreg = {shreg[WORD_W-2:0], chain_bit};
				if (loaded && bit_cnt != WORD_LAST)
					next_bit_cnt = bit_cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state    <= ASRP_IDLE;
			shreg    <= '0;
			serial_data_output    <= 1'b0;
			bit_cnt  <= '0;
			sclk_raw <= 1'b0;
			loaded   <= 1'b0;
			ext_prev <= 1'b0;
			result_q <= '0;
		end
		else
		begin
			state    <= next_state;
			shreg    <= next_shreg;
			serial_data_output    <= next_serial_data_output;
			bit_cnt  <= next_bit_cnt;
			sclk_raw <= next_sclk_raw;
			loaded   <= next_loaded;
			ext_prev <= ext_eff;
			if (conv_done)
				result_q <= coded_in;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tick_cnt <= '0;
			phase    <= 2'd0;
		end
		else if (state != ASRP_RUN || tick)
		begin
			tick_cnt <= '0;
			phase    <= (state == ASRP_RUN) ? phase + 2'd1 : 2'd0;
		end
		else
			tick_cnt <= tick_cnt + TICK_W'(1);
	end

	// ----------------------------------------------------------------
	// shared pins
	// ----------------------------------------------------------------
	wire in_frame = state == ASRP_RUN;
	logic [SHARED_W-1:0] next_pin_out;
	logic [SHARED_W-1:0] next_pin_oe;
	always_comb
	begin
		// parallel style drives result bits on every shared pin
		next_pin_out = result_q[SHARED_LSB +: SHARED_W];
		next_pin_oe  = '1;
		if (serial_s)
		begin
			next_pin_out = '0;
			next_pin_oe  = '0;
			next_pin_out[PIN_SERIAL_DATA_OUTPUT] = serial_data_output;
			next_pin_oe[PIN_SERIAL_DATA_OUTPUT]  = 1'b1;
			// internal clock driven, inverted on request
			// gated by the frame: an aborted frame cannot leave it at the active level
			next_pin_out[PIN_SCLK] = (sclk_raw && in_frame) ^ sclk_inv;
			next_pin_oe[PIN_SCLK]  = !ext_s;
			next_pin_out[PIN_FRAME] = (in_frame && master) ? !sync_pol : sync_pol;
			next_pin_oe[PIN_FRAME]  = 1'b1;
			next_pin_out[PIN_OVERRUN] = ovr_evt;
			next_pin_oe[PIN_OVERRUN]  = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_d_out <= '0;
			pin_d_oe  <= '0;
		end
		else
		begin
			pin_d_out <= next_pin_out;
			pin_d_oe  <= next_pin_oe;
		end
	end

	// ----------------------------------------------------------------
	// status, mask and interrupt
	// ----------------------------------------------------------------
	wire hit_status = reg_addr == REG_STATUS_OFS;
	wire hit_mask   = reg_addr == REG_MASK_OFS;
	wire [STAT_W-1:0] events = {frame_evt, ovr_evt};
	// a read clears, but an event in the same cycle survives
	wire [STAT_W-1:0] next_status = (reg_rd && hit_status) ? events : (status | events);
	wire [STAT_W-1:0] next_mask   = (reg_wr && hit_mask) ? reg_wdata[STAT_W-1:0] : mask;
	wire [31:0] next_rdata = !reg_rd ? 32'h0 :
		hit_status ? {{(32-STAT_W){1'b0}}, status} :
		hit_mask   ? {{(32-STAT_W){1'b0}}, mask} : 32'h0;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			status    <= STATUS_RESET;
			mask      <= MASK_RESET;
			reg_rdata <= 32'h0;
			irq       <= 1'b0;
		end
		else
		begin
			status    <= next_status;
			mask      <= next_mask;
			reg_rdata <= next_rdata;
			irq       <= |(next_status & next_mask);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_parallel_bits: assert property (!serial_s |=> pin_d_out == $past(result_q[SHARED_LSB +: SHARED_W]) && &pin_d_oe)
		else $error("parallel pins do not show result bits");
	a_frame_idle_level: assert property (serial_s && !in_frame |=> pin_d_out[PIN_FRAME] == $past(sync_pol))
		else $error("frame marker idle level wrong");
	a_sclk_idle_invert: assert property (master && !in_frame |=> pin_d_out[PIN_SCLK] == $past(sclk_inv))
		else $error("idle serial clock ignores inversion");
	a_msb_first_out: assert property (start_evt |=> ##1 pin_d_out[PIN_SERIAL_DATA_OUTPUT] == $past(load_word[WORD_W-1], 2))
		else $error("first bit is not the top bit");
	a_coding_top_bit: assert property (conv_done |=> result_q[WORD_W-1] == ($past(conv_result[WORD_W-1]) ^ ~$past(coding_s)))
		else $error("top bit coding wrong");
	a_sclk_direction: assert property (serial_s |=> pin_d_oe[PIN_SCLK] == !$past(ext_s))
		else $error("clock pin direction wrong");
	a_frame_held: assert property (start_evt && !sync_pol ##1 master [*8] |-> ##1 pin_d_out[PIN_FRAME] [*7])
		else $error("frame marker dropped early");
	a_overrun_pulse: assert property (ovr_evt |=> pin_d_out[PIN_OVERRUN] ##1 (!pin_d_out[PIN_OVERRUN] || $past(ovr_evt)))
		else $error("overrun flag not a single pulse");
	a_cs_gates_clock: assert property (slave && cs_n_s && !conv_done |=> serial_data_output == $past(serial_data_output))
		else $error("external clock not gated by chip select");
	a_overrun_flagged: assert property (slave && loaded && bit_cnt < WORD_LAST && conv_done |=> status[STAT_OVERRUN])
		else $error("incomplete read not flagged");
	c_master_frame: cover property (master_done);
	c_slave_read: cover property (slave_done);
	c_overrun: cover property (ovr_evt);
	c_irq: cover property (irq ##1 reg_rd && hit_status);

endmodule

`default_nettype wire

// ### hw/asrp_pkg.sv
/*
 * shared constants for the converter serial result port: pin positions
 * in the shared group, register offsets, status layout, timing, states.
 * assumes a 200 MHz core clock and a 16-bit conversion result.
 */
`default_nettype none

package asrp_pkg;

	// ----------------------------------------------------------------
	// result and shared pins
	// ----------------------------------------------------------------
	localparam int RESULT_W      = 16;
	localparam int SHARED_W      = 7;
	localparam int SHARED_LSB    = 5;
	localparam int PIN_SYNC_POL  = 0;
	localparam int PIN_SCLK_INV  = 1;
	localparam int PIN_CHAIN     = 2;
	localparam int PIN_SERIAL_DATA_OUTPUT     = 3;
	localparam int PIN_SCLK      = 4;
	localparam int PIN_FRAME     = 5;
	localparam int PIN_OVERRUN   = 6;

	// ----------------------------------------------------------------
	// input synchroniser layout: {cs_n, style, source, coding, pins}
	// ----------------------------------------------------------------
	localparam int SYNC_W        = SHARED_W + 4;
	localparam int SYNC_CODING   = SHARED_W;
	localparam int SYNC_SOURCE   = SHARED_W + 1;
	localparam int SYNC_STYLE    = SHARED_W + 2;
	localparam int SYNC_CS_N     = SHARED_W + 3;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 11'h400;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 5;
	localparam int SCLK_QUARTER_NS  = 20;
	localparam int SCLK_QUARTER_CYC = (SCLK_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_STATUS_OFS = 4'h0;
	localparam logic [3:0] REG_MASK_OFS   = 4'h4;
	localparam int         STAT_W         = 2;
	localparam int         STAT_OVERRUN   = 0;
	localparam int         STAT_FRAME     = 1;
	localparam logic [STAT_W-1:0] STATUS_RESET = 2'h0;
	localparam logic [STAT_W-1:0] MASK_RESET   = 2'h0;

	typedef enum logic [0:0] {ASRP_IDLE, ASRP_RUN} asrp_state_type;

endpackage

`default_nettype wire

// ### dv/asrp_host.sv
/*
 * host serial port model: clocks frames on the converter's serial clock pin
 * and samples the data pin on the edge after each update.
 * assumes the bench sets the invert level before calling read_frame.
 */
`default_nettype none

module asrp_host (
	input  wire logic        inv,
	input  wire logic        sdata,
	output var  logic        sclk,
	output var  logic        cs_n,
	output var  logic [16:0] word
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		word = 17'h0;
	end

	// 80 ns clock only inside a frame; gated edges come first
	task automatic read_frame(input int gated, input int n);
		int i;
		#3 sclk = inv;
		#40;
		for (i = 0; i < gated + n; i++)
		begin
			// select low lets the clock through
			cs_n = (i < gated);
			#20 sclk = ~inv;
			#40 sclk = inv;
			// sample on the edge after the update
			word = {word[15:0], sdata};
			#20;
		end
		cs_n = 1'b1;
	endtask
endmodule

`default_nettype wire

// ### dv/asrp_port_tb.sv
/*
 * self-checking bench for the serial result port: parallel pins, master
 * frames, slave reads with chaining, overrun, registers and interrupt.
 * assumes asrp_pkg and the host model are compiled first.
 */
`default_nettype none

module asrp_port_tb;
	import asrp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int QC = 1;
	logic          core_clk = 1'b0;
	logic          arst_n = 1'b0;
	logic          style = 1'b0;
	logic          src = 1'b0;
	logic          coding = 1'b1;
	logic          sp = 1'b0;
	logic          inv = 1'b0;
	logic          chain = 1'b0;
	logic          conv_start = 1'b0;
	logic          conv_done = 1'b0;
	logic [15:0]   conv_result = 16'h0;
	logic [3:0]    reg_addr = 4'h0;
	logic [31:0]   reg_wdata = 32'h0;
	logic          reg_wr = 1'b0;
	logic          reg_rd = 1'b0;
	wire  logic    sclk;
	wire  logic    cs_n;
	wire  logic [16:0] hword;
	wire  logic [6:0] pin_d_in;
	wire  logic [6:0] pin_d_out;
	wire  logic [6:0] pin_d_oe;
	wire  logic [31:0] reg_rdata;
	wire  logic    irq;
	int            n_mismatch = 0;
	int            checks_done = 0;
	logic [31:0]   rd;
	logic [15:0]   r;
	int            i;
	int            k;

	// ------------------------------------------------------------
	// clock, pins, instances
	// ------------------------------------------------------------
	initial
	begin
		forever #2.5 core_clk = ~core_clk;
	end

	// shared pins: whoever enables wins
	assign pin_d_in = (pin_d_oe & pin_d_out) | (~pin_d_oe & {2'b00, sclk, 1'b0, chain, inv, sp});

	asrp_host host (.inv(inv), .sdata(pin_d_out[3]), .sclk(sclk), .cs_n(cs_n), .word(hword));

	asrp_port #(.QUARTER_CYC(QC)) dut (
		.core_clk(core_clk), .arst_n(arst_n), .port_style_select(style),
		.clock_source_select(src), .output_coding_select(coding), .cs_n(cs_n),
		.conv_start(conv_start), .conv_done(conv_done), .conv_result(conv_result),
		.pin_d_in(pin_d_in), .pin_d_out(pin_d_out), .pin_d_oe(pin_d_oe),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	function automatic logic [15:0] coded(input logic [15:0] v, input logic c);
		return c ? v : v ^ 16'h8000;
	endfunction

	task automatic tk(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic pulse(input logic st, input logic [15:0] v);
		conv_result <= v;
		conv_start <= st;
		conv_done <= ~st;
		@(posedge core_clk);
		conv_start <= 1'b0;
		conv_done <= 1'b0;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
		@(posedge core_clk);
	endtask

	// watches the marker and latches data at each effective clock rise
	task automatic master_frame(input logic [15:0] exp);
		logic [15:0] w;
		logic [15:0] wf;
		logic        pe;
		int          act;
		int          t;
		w = 16'h0;
		wf = 16'h0;
		pe = 1'b0;
		act = 0;
		for (t = 0; t < 200; t++)
		begin
			@(negedge core_clk);
			act += (pin_d_out[5] === ~sp);
			if ((pin_d_out[4] ^ inv) && !pe)
				w = {w[14:0], pin_d_out[3]};
			if (!(pin_d_out[4] ^ inv) && pe)
				wf = {wf[14:0], pin_d_out[3]};
			pe = pin_d_out[4] ^ inv;
		end
		check("marker cycles", act, 64 * QC);
		check("master word", w, exp);
		check("master word at fall", wf, exp);
		check("clock pin drive", pin_d_oe[4], 1'b1);
		@(posedge core_clk);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		#400us;
		n_mismatch++;
		print_verdict();
	end

	initial
	begin
		void'($urandom(32'he1a1));
		tk(3);
		arst_n <= 1'b1;
		tk(4);
		reg_read(REG_MASK_OFS, rd);
		check("mask reset", rd, 32'h0);
		reg_write(REG_MASK_OFS, 32'hffffffff);
		reg_read(REG_MASK_OFS, rd);
		check("mask upper bits", rd, 32'h3);
		reg_read(4'h8, rd);
		check("unmapped read", rd, 32'h0);
		$display("test registers done");
		for (i = 0; i < 4; i++)
		begin
			r = 16'($urandom);
			pulse(1'b0, r);
			tk(3);
			check("parallel pins", pin_d_out, r[11:5]);
			check("parallel enables", pin_d_oe, 7'h7f);
		end
		$display("test parallel done");
		style <= 1'b1;
		// shared pins turn around one cycle late, then pass the synchroniser
		tk(2);
		for (i = 0; i < 8; i++)
		begin
			{chain, inv, sp} <= i[2:0];
			coding <= 1'($urandom);
			tk(4);
			r = 16'($urandom);
			pulse(1'b0, r);
			// high read mode sends the latched word on the next start
			if (chain)
			begin
				tk(2);
				pulse(1'b1, 16'h0);
			end
			master_frame(coded(r, coding));
		end
		$display("test master done");
		src <= 1'b1;
		for (i = 0; i < 4; i++)
		begin
			{chain, inv} <= i[1:0];
			coding <= 1'($urandom);
			tk(4);
			r = 16'($urandom);
			pulse(1'b0, r);
			tk(2);
			host.read_frame(3, 17);
			@(posedge core_clk);
			check("slave word", hword, {coded(r, coding), chain});
			check("clock pin input", pin_d_oe[4], 1'b0);
		end
		$display("test slave done");
		reg_read(REG_STATUS_OFS, rd);
		check("status after reads", rd, 32'h2);
		r = 16'($urandom);
		pulse(1'b0, 16'h1234);
		host.read_frame(0, 5);
		@(posedge core_clk);
		pulse(1'b0, r);
		k = 0;
		repeat (10)
		begin
			@(negedge core_clk);
			k += (pin_d_out[6] === 1'b1);
		end
		check("overrun pulse cycles", k, 1);
		check("irq raised", irq, 1'b1);
		@(posedge core_clk);
		reg_read(REG_STATUS_OFS, rd);
		check("overrun status", rd[STAT_OVERRUN], 1'b1);
		tk(2);
		check("irq cleared", irq, 1'b0);
		host.read_frame(0, 17);
		@(posedge core_clk);
		check("replaced word", hword, {coded(r, coding), chain});
		$display("test overrun done");
		print_verdict();
	end
endmodule

`default_nettype wire
